// [sensor_event_pin_logic.sv]
// event latch, alert pin and proximity logic output for the sensor
// Contract
// - event latch holds two flags per light and proximity interrupt source
// - in normal mode, any flag rising from 0 to 1 drives the alert pin low
// - host read clears set flags after data returned; pin returns high
// - logic output mode: pin low while object near, high when away
// - logic mode pin shows only near/far; light events only in normal mode
// - proximity thresholds decide near/far in both modes
// - proximity event above upper threshold; none between the thresholds
// - enabled light event when count above upper or below lower threshold
// - proximity close event only after persistence count of periods above upper; away event on one sample below lower
`timescale 1ns/1ps
module sensor_event_pin_logic #(
	parameter int COUNT_W = sensor_event_pkg::COUNT_W,
	parameter int PERS_W = sensor_event_pkg::PERS_W
) (
	input wire logic clk,
	input wire logic resetn,
	// one-cycle strobes from the measurement engines, same clock
	input wire logic proximityDone,
	input wire logic [COUNT_W-1:0] proximityCount,
	input wire logic lightDone,
	input wire logic [COUNT_W-1:0] lightCount,
	// configuration
	input wire logic proximityInterruptEnable,
	input wire logic lightInterruptEnable,
	input wire logic proximityLogicOutputSelect,
	input wire logic [COUNT_W-1:0] proximityUpperThreshold,
	input wire logic [COUNT_W-1:0] proximityLowerThreshold,
	input wire logic [COUNT_W-1:0] lightUpperThreshold,
	input wire logic [COUNT_W-1:0] lightLowerThreshold,
	input wire logic [PERS_W-1:0] proximityPersistenceCount,
	// host read of the latch: pulse once the read data has been returned
	input wire logic flagReadDone,
	output logic [sensor_event_pkg::FLAG_W-1:0] eventFlags,
	output logic proximityNear,
	output logic alertOrPresencePin
);
	// ---------------------------------------------------------------
	// proximity near/far tracking with persistence
	// ---------------------------------------------------------------
	sensor_event_pkg::prox_state_t proxState_q, proxState_d;
	logic [PERS_W-1:0] persCnt_q, persCnt_d;
	logic proxCloseEvt, proxAwayEvt;
	// a lower threshold set above the upper one leaves no band between
	// them, so the hysteresis is lost; keeping them ordered is up to the host

	always_comb begin
		proxState_d = proxState_q;
		persCnt_d = persCnt_q;
		proxCloseEvt = 1'b0;
		proxAwayEvt = 1'b0;
		if (proximityDone) begin
			case (proxState_q)
				sensor_event_pkg::PROX_FAR: begin
					// between thresholds the state holds (hysteresis); the persistence count clears
					if (proximityCount > proximityUpperThreshold) begin
						// persistence 0 is treated as one period
						if (persCnt_q + 1'b1 >= proximityPersistenceCount) begin
							proxState_d = sensor_event_pkg::PROX_NEAR;
							proxCloseEvt = 1'b1;
							persCnt_d = sensor_event_pkg::PERS_RESET;
						end else begin
							persCnt_d = persCnt_q + 1'b1;
						end
					end else begin
						persCnt_d = sensor_event_pkg::PERS_RESET;
					end
				end
				default: begin
					if (proximityCount < proximityLowerThreshold) begin
						proxState_d = sensor_event_pkg::PROX_FAR;
						proxAwayEvt = 1'b1;
					end
					persCnt_d = sensor_event_pkg::PERS_RESET;
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			proxState_q <= sensor_event_pkg::PROX_FAR;
			persCnt_q <= sensor_event_pkg::PERS_RESET;
		end else begin
			proxState_q <= proxState_d;
			persCnt_q <= persCnt_d;
		end
	end

	// ---------------------------------------------------------------
	// event latch and alert pin
	// ---------------------------------------------------------------
	logic [sensor_event_pkg::FLAG_W-1:0] flags_q, flags_d, setMask;
	logic pin_q, pin_d, near_q;

	always_comb begin
		setMask = '0;
		setMask[sensor_event_pkg::FLAG_PROX_CLOSE] =
			proxCloseEvt & proximityInterruptEnable;
		setMask[sensor_event_pkg::FLAG_PROX_AWAY] =
			proxAwayEvt & proximityInterruptEnable;
		setMask[sensor_event_pkg::FLAG_LIGHT_HIGH] = lightDone
			& lightInterruptEnable
			& (lightCount > lightUpperThreshold);
		setMask[sensor_event_pkg::FLAG_LIGHT_LOW] = lightDone
			& lightInterruptEnable
			& (lightCount < lightLowerThreshold);
		// a new event in the clearing cycle survives the read
		flags_d = flagReadDone ? setMask : (flags_q | setMask);
		// logic mode reads the next proximity state, so the pin and the
		// near flop always change on the same edge
		if (proximityLogicOutputSelect == sensor_event_pkg::MODE_LOGIC_OUT)
			pin_d = (proxState_d != sensor_event_pkg::PROX_NEAR);
		else
			pin_d = (flags_d == '0);
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			flags_q <= sensor_event_pkg::FLAGS_RESET;
			pin_q <= sensor_event_pkg::PIN_IDLE;
			near_q <= 1'b0;
		end else begin
			flags_q <= flags_d;
			pin_q <= pin_d;
			near_q <= (proxState_d == sensor_event_pkg::PROX_NEAR);
		end
	end

	assign eventFlags = flags_q;
	assign alertOrPresencePin = pin_q;
	assign proximityNear = near_q;

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	sequence s_flagRise;
		!flagReadDone && (setMask != '0);
	endsequence

	a_flag_pulls_pin: assert property (
		s_flagRise and !proximityLogicOutputSelect |=> !alertOrPresencePin)
		else $error("alert pin not low after flag set");
	a_read_clears_flags: assert property (
		flagReadDone && setMask == '0 |=> eventFlags == '0)
		else $error("flags not cleared by read");
	a_read_releases_pin: assert property (
		flagReadDone && setMask == '0 && !proximityLogicOutputSelect
		|=> alertOrPresencePin)
		else $error("alert pin not released after read");
	a_logic_pin_near: assert property (
		proximityLogicOutputSelect |=> alertOrPresencePin == !proximityNear)
		else $error("logic output does not follow near state");
	a_logic_ignores_light: assert property (
		proxState_d == proxState_q && proximityLogicOutputSelect
		&& $past(proximityLogicOutputSelect) |=> $stable(alertOrPresencePin))
		else $error("pin moved without proximity change");
	a_hyst_hold: assert property (
		proximityDone && proximityCount <= proximityUpperThreshold
		&& proximityCount >= proximityLowerThreshold
		|=> $stable(proxState_q))
		else $error("state changed inside hysteresis band");
	a_light_flag_set: assert property (
		lightDone && lightInterruptEnable
		&& lightCount > lightUpperThreshold
		|=> eventFlags[sensor_event_pkg::FLAG_LIGHT_HIGH])
		else $error("light high flag missed");
	a_persist_three: assert property (
		proximityPersistenceCount == 3'h3 && proxState_q == sensor_event_pkg::PROX_FAR
		&& persCnt_q == 3'h0 && proximityDone
		|=> proxState_q == sensor_event_pkg::PROX_FAR)
		else $error("near reached before persistence count");
	a_reset_idle: assert property (
		$rose(resetn) |-> eventFlags == '0 && alertOrPresencePin)
		else $error("not idle after reset");

	// proximity sample above the upper threshold at persistence three
	sequence s_aboveUpper;
		proximityDone && proximityCount > proximityUpperThreshold
			&& proximityPersistenceCount == 3'h3;
	endsequence

	// three such samples in a row, starting from a clean far state
	sequence s_threeAbove;
		proxState_q == sensor_event_pkg::PROX_FAR && persCnt_q == 3'h0
			##0 s_aboveUpper ##1 s_aboveUpper ##1 s_aboveUpper;
	endsequence

	// a near object dropping below the lower threshold
	sequence s_dropBelow;
		proximityDone && proxState_q == sensor_event_pkg::PROX_NEAR
			&& proximityCount < proximityLowerThreshold;
	endsequence

	a_persist_reach: assert property (
		s_threeAbove |=> proximityNear)
		else $error("near not reached after persistence count");
	a_far_on_drop: assert property (
		s_dropBelow |=> !proximityNear)
		else $error("near state held below lower threshold");
	a_away_flag_set: assert property (
		s_dropBelow and proximityInterruptEnable
		|=> eventFlags[sensor_event_pkg::FLAG_PROX_AWAY])
		else $error("proximity away flag missed");
	a_close_flag_set: assert property (
		proximityDone && proximityInterruptEnable
		&& proxState_q == sensor_event_pkg::PROX_FAR
		&& proximityCount > proximityUpperThreshold
		&& proximityPersistenceCount <= 3'h1
		|=> eventFlags[sensor_event_pkg::FLAG_PROX_CLOSE])
		else $error("proximity close flag missed");
	a_light_low_set: assert property (
		lightDone && lightInterruptEnable
		&& lightCount < lightLowerThreshold
		|=> eventFlags[sensor_event_pkg::FLAG_LIGHT_LOW])
		else $error("light low flag missed");
	a_light_disabled: assert property (
		!lightInterruptEnable && !flagReadDone
		|=> $stable(eventFlags[sensor_event_pkg::FLAG_LIGHT_LOW:
			sensor_event_pkg::FLAG_LIGHT_HIGH]))
		else $error("light flag moved while disabled");
endmodule : sensor_event_pin_logic

// [sensor_event_pkg.sv]
// shared constants for the sensor event pin logic
package sensor_event_pkg;
	// ---------------------------------------------------------------
	// widths and field positions
	// ---------------------------------------------------------------
	localparam int COUNT_W = 16;
	localparam int PERS_W = 3;
	localparam int FLAG_W = 4;
	// flag bit positions in the event latch
	localparam int FLAG_PROX_CLOSE = 0;
	localparam int FLAG_PROX_AWAY = 1;
	localparam int FLAG_LIGHT_HIGH = 2;
	localparam int FLAG_LIGHT_LOW = 3;
	// ---------------------------------------------------------------
	// reset values
	// ---------------------------------------------------------------
	localparam logic [3:0] FLAGS_RESET = 4'h0;
	localparam logic PIN_IDLE = 1'b1;
	localparam logic [2:0] PERS_RESET = 3'h0;
	// mode select encodings
	localparam logic MODE_NORMAL = 1'b0;
	localparam logic MODE_LOGIC_OUT = 1'b1;

	typedef enum logic [1:0] {
		PROX_FAR = 2'b00,
		PROX_NEAR = 2'b01
	} prox_state_t;
endpackage : sensor_event_pkg

// [host_model.sv]
// host side: answers a low alert pin with a latch read
`timescale 1ns/1ps
module host_model (
	input wire logic clk,
	input wire logic resetn,
	input wire logic autoRead,
	input wire logic [2:0] latency,
	input wire logic alertOrPresencePin,
	output logic flagReadDone
);
	logic [2:0] wait_q = 3'h0;
	initial flagReadDone = 1'b0;
	// pin used as interrupt input; read pulse is one cycle
	always @(negedge clk) begin
		flagReadDone <= 1'b0;
		wait_q <= wait_q + 3'h1;
		if (!resetn || !autoRead || alertOrPresencePin) begin
			wait_q <= 3'h0;
		end else if (wait_q >= latency) begin
			flagReadDone <= 1'b1;
			wait_q <= 3'h0;
		end
	end
endmodule : host_model

// [testbench.sv]
// random self-checking bench with a reference model
`timescale 1ns/1ps
module testbench;
	localparam logic [15:0] UP = 16'h8000;
	localparam logic [15:0] LO = 16'h4000;
	logic clk = 0, resetn = 0, pD = 0, lD = 0, pE = 0, lE = 0, sel = 0;
	logic [15:0] pC = 16'h0000, lC = 16'h0000;
	logic [15:0] pUp = UP, pLo = LO, lUp = UP, lLo = LO;
	logic [2:0] pers = 3'h0, lat = 3'h0, mRun;
	logic auto = 0, rd, near, pin, mNear;
	logic [3:0] flags, mF, f;
	int n_errors = 0, checked = 0;
	always #25 clk = ~clk;
	sensor_event_pin_logic dut_u (.clk(clk), .resetn(resetn),
		.proximityDone(pD), .proximityCount(pC), .lightDone(lD),
		.lightCount(lC), .proximityInterruptEnable(pE),
		.lightInterruptEnable(lE), .proximityLogicOutputSelect(sel),
		.proximityUpperThreshold(pUp), .proximityLowerThreshold(pLo),
		.lightUpperThreshold(lUp), .lightLowerThreshold(lLo),
		.proximityPersistenceCount(pers), .flagReadDone(rd),
		.eventFlags(flags), .proximityNear(near), .alertOrPresencePin(pin));
	host_model host_u (.clk(clk), .resetn(resetn), .autoRead(auto),
		.latency(lat), .alertOrPresencePin(pin), .flagReadDone(rd));
	// reference model; the set of a same-cycle event beats the read clear
	always @(posedge clk) begin
		f = rd ? 4'h0 : mF;
		if (!resetn) begin
			f = 4'h0;
			mNear = 0;
			mRun = 3'h0;
		end else if (pD && pC > pUp) begin
			mRun = (mRun == 3'h7) ? mRun : mRun + 3'h1;
			if (!mNear && mRun >= ((pers == 0) ? 3'h1 : pers)) begin
				mNear = 1;
				f[0] = f[0] | pE;
			end
		end else if (pD) begin
			mRun = 3'h0;
			if (mNear && pC < pLo) begin
				mNear = 0;
				f[1] = f[1] | pE;
			end
		end
		if (resetn && lD && lE) begin
			f[2] = f[2] | (lC > lUp);
			f[3] = f[3] | (lC < lLo);
		end
		mF = f;
	end
	task automatic check(string n, logic [3:0] s, logic [3:0] e);
		checked++;
		if (s !== e) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", n, e, s);
		end
	endtask : check
	function automatic logic expPin(logic s, logic n, logic [3:0] fl);
		return s ? ~n : ~|fl;
	endfunction : expPin
	function automatic logic [15:0] pick(logic [15:0] hi, logic [15:0] lo);
		case ($urandom_range(0, 4))
			0: return hi;
			1: return hi + 16'h0001;
			2: return lo;
			3: return lo - 16'h0001;
			default: return 16'($urandom);
		endcase
	endfunction : pick
	task automatic run(int t, int cyc);
		for (int i = 0; i < cyc; i++) begin
			@(negedge clk);
			check("eventFlags", flags, mF);
			check("proximityNear", {3'h0, near}, {3'h0, mNear});
			check("pin", {3'h0, pin}, {3'h0, expPin(sel, mNear, mF)});
			pD = $urandom_range(0, 2) == 0;
			lD = $urandom_range(0, 3) == 0;
			pC = pick(pUp, pLo);
			lC = pick(lUp, lLo);
			// corner: drop below lower, then a run of samples above upper
			if (i % 64 == 60) begin
				pD = 1;
				pC = pLo - 16'h0001;
			end else if (i % 64 < 3) begin
				pD = 1;
				pC = pUp + 16'h0001;
			end
		end
		$display("test %0d done", t);
	endtask : run
	task automatic final_report();
		$display("comparisons %0d mismatches %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : final_report
	initial begin
		#(50 * 20000);
		n_errors++;
		final_report();
	end
	initial begin
		void'($urandom(32'h32f6));
		run(0, 4);
		resetn = 1;
		for (int t = 1; t <= 16; t++) begin
			sel = t[0];
			pers = 3'(t / 2);
			pE = t != 5;
			lE = t != 6;
			auto = t[1];
			lat = 3'($urandom);
			pUp = t[2] ? 16'h6000 : UP;
			pLo = t[3] ? 16'h2000 : LO;
			lUp = t[3] ? 16'h6000 : UP;
			lLo = t[2] ? 16'h2000 : LO;
			resetn = t != 9;
			run(t, 400);
		end
		final_report();
	end
endmodule : testbench
